// [src/vc0_arb_consts.vh]
// Register map, field positions and reset values of the VC0 arbitration table block.
// Included by the design file; holds definitions only.
`ifndef VC0_ARB_CONSTS_VH
`define VC0_ARB_CONSTS_VH

`define OFS_STATUS      12'h218
`define OFS_CONTROL     12'h21C
`define OFS_TABLE0      12'h220
`define OFS_TABLE1      12'h224
`define OFS_TABLE2      12'h228
`define OFS_TABLE3      12'h22C
`define OFS_IRQ_STATUS  12'h230
`define OFS_IRQ_MASK    12'h234
`define OFS_ARB_CONFIG  12'h238

`define BIT_COHERENCY   0
`define BIT_FLOW_INIT   1
`define BIT_LOAD_TABLE  16
`define BIT_TABLE_USED  0

`define IRQ_LOAD_DONE   0
`define IRQ_TABLE_WRITE 1
`define IRQ_FLOW_DONE   2
`define IRQ_WIDTH       3

`define RST_TABLE0      32'h1765_4321
`define RST_TABLE1      32'h2176_5432
`define RST_TABLE2      32'h3217_6543
`define RST_TABLE3      32'h4321_7654

`define PORT_UP         4'h0
`define PORT_2          4'h2
`define PORT_3          4'h3
`define PORT_4          4'h4

`endif

// [src/vc0_port_arb_table.v]
// VC0 port arbitration table: APB register slave, phase table, latched arbiter copy,
// coherency and flow-init status, and sticky interrupt status with mask.
// Assumes APB on pclk; flow_init_busy and is_downstream come from other clocks or pins.
//
// Overview of operation
// - Any software write to a table word sets the coherency pending bit.
// - The coherency bit stays set until the table latch that follows a load strobe has finished.
// - The coherency bit only carries meaning when the selected scheme uses the table.
// - A downstream port always reads the coherency bit as zero.
// - Status bit 1 shows that flow control initialization is pending, read-only, reset zero.
// - Each phase is a 4-bit port field, eight per word, phase 0 in the lowest nibble.
// - A phase naming an invalid port is skipped at once without spending a period in it.
// - Codes 0x0, 0x2, 0x3 and 0x4 select ports 0, 2, 3 and 4; 0x5 to 0xF are reserved.
// - Phases reset to the repeating pattern 0x1 through 0x7 starting at phase 0.
// - A one in control bit 16 loads the table, zero does nothing, it reads zero, upstream only.
// - The table continues in the same packing up to phase 31 in the fourth word.
`include "vc0_arb_consts.vh"

module vc0_port_arb_table #(
  parameter PHASES     = 32,
  parameter LOAD_TICKS = 4,
  parameter EGRESS_ID  = 4'h1
) (
  // Clock, enable and reset.
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Asynchronous status inputs.
  input  wire        flow_init_busy,
  input  wire        is_downstream,
  // Arbiter side.
  input  wire        period_tick,
  output reg  [3:0]  grant_port,
  output reg         grant_valid,
  output wire        irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_LOAD = 1'b1;

  reg  [31:0] table_r   [0:3];
  reg  [31:0] latched_r [0:3];
  reg         coherency_r;
  reg         load_state_r;
  reg  [7:0]  load_cnt_r;
  reg  [4:0]  ptr_r;
  reg  [`IRQ_WIDTH-1:0] irq_sts_r;
  reg  [`IRQ_WIDTH-1:0] irq_mask_r;
  reg         table_used_r;
  reg  [1:0]  flow_sync_r;
  reg  [1:0]  down_sync_r;
  reg         flow_prev_r;

  wire        wr_en  = psel & penable & pwrite & clk_en;
  wire        rd_sel;
  wire        is_tbl = (paddr[11:4] == 8'h22);
  wire [1:0]  tbl_ix = paddr[3:2];
  wire        flow_s = flow_sync_r[1];
  wire        down_s = down_sync_r[1];
  wire        tbl_wr = wr_en & is_tbl;
  wire        load_req = wr_en & (paddr == `OFS_CONTROL) &
                         pwdata[`BIT_LOAD_TABLE] & ~down_s;
  wire        load_done = (load_state_r == ST_LOAD) & (load_cnt_r == 8'h00);
  wire [`IRQ_WIDTH-1:0] irq_evt;
  wire        mapped;

  assign irq_evt[`IRQ_LOAD_DONE]   = load_done;
  assign irq_evt[`IRQ_TABLE_WRITE] = tbl_wr;
  assign irq_evt[`IRQ_FLOW_DONE]   = flow_prev_r & ~flow_s;
  assign irq    = |(irq_sts_r & irq_mask_r);
  assign pready = 1'b1;
  assign mapped = is_tbl | (paddr == `OFS_STATUS) | (paddr == `OFS_CONTROL) |
                  (paddr == `OFS_IRQ_STATUS) | (paddr == `OFS_IRQ_MASK) |
                  (paddr == `OFS_ARB_CONFIG);
  assign pslverr = psel & penable & ~mapped;
  assign rd_sel  = psel & ~penable & ~pwrite;

  // Current latched phase, decoded for validity.
  wire [3:0] cur_phase = latched_r[ptr_r[4:3]][{ptr_r[2:0], 2'b00} +: 4];
  wire       cur_valid = (cur_phase == `PORT_UP) | (cur_phase == `PORT_2) |
                         (cur_phase == `PORT_3) | (cur_phase == `PORT_4);
  wire       cur_ok    = cur_valid & (cur_phase != EGRESS_ID);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_sync_r <= 2'b00;
      down_sync_r <= 2'b00;
      flow_prev_r <= 1'b0;
    end else if (clk_en) begin
      flow_sync_r <= {flow_sync_r[0], flow_init_busy};
      down_sync_r <= {down_sync_r[0], is_downstream};
      flow_prev_r <= flow_s;
    end
  end

  // Table words and coherency tracking.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_r[0]   <= `RST_TABLE0;
      table_r[1]   <= `RST_TABLE1;
      table_r[2]   <= `RST_TABLE2;
      table_r[3]   <= `RST_TABLE3;
      coherency_r  <= 1'b0;
      table_used_r <= 1'b1;
      irq_mask_r   <= {`IRQ_WIDTH{1'b0}};
    end else if (clk_en) begin
      if (tbl_wr)
        table_r[tbl_ix] <= pwdata;
      if (tbl_wr)
        coherency_r <= 1'b1;
      else if (load_done)
        coherency_r <= 1'b0;
      if (wr_en && paddr == `OFS_ARB_CONFIG)
        table_used_r <= pwdata[`BIT_TABLE_USED];
      if (wr_en && paddr == `OFS_IRQ_MASK)
        irq_mask_r <= pwdata[`IRQ_WIDTH-1:0];
    end
  end

  // Load sequence copies the table into the arbiter over LOAD_TICKS cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_state_r <= ST_IDLE;
      load_cnt_r   <= 8'h00;
      latched_r[0] <= `RST_TABLE0;
      latched_r[1] <= `RST_TABLE1;
      latched_r[2] <= `RST_TABLE2;
      latched_r[3] <= `RST_TABLE3;
    end else if (clk_en) begin
      case (load_state_r)
        ST_IDLE: begin
          if (load_req) begin
            load_state_r <= ST_LOAD;
            load_cnt_r   <= LOAD_TICKS[7:0] - 8'h01;
          end
        end
        ST_LOAD: begin
          if (load_cnt_r == 8'h00) begin
            latched_r[0] <= table_r[0];
            latched_r[1] <= table_r[1];
            latched_r[2] <= table_r[2];
            latched_r[3] <= table_r[3];
            load_state_r <= ST_IDLE;
          end else begin
            load_cnt_r <= load_cnt_r - 8'h01;
          end
        end
        default: load_state_r <= ST_IDLE;
      endcase
    end
  end

  // Sticky interrupt status; a new event wins over a same-cycle clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_sts_r <= {`IRQ_WIDTH{1'b0}};
    else if (clk_en) begin
      if (wr_en && paddr == `OFS_IRQ_STATUS)
        irq_sts_r <= (irq_sts_r & ~pwdata[`IRQ_WIDTH-1:0]) | irq_evt;
      else
        irq_sts_r <= irq_sts_r | irq_evt;
    end
  end

  // Arbiter pointer: invalid phases are passed over in one cycle without a grant.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r       <= 5'h00;
      grant_port  <= 4'h0;
      grant_valid <= 1'b0;
    end else if (clk_en) begin
      grant_valid <= 1'b0;
      if (!cur_ok) begin
        ptr_r <= (ptr_r == PHASES[4:0] - 5'h01) ? 5'h00 : ptr_r + 5'h01;
      end else if (period_tick) begin
        grant_port  <= cur_phase;
        grant_valid <= 1'b1;
        ptr_r <= (ptr_r == PHASES[4:0] - 5'h01) ? 5'h00 : ptr_r + 5'h01;
      end
    end
  end

  // Read data is captured in the setup cycle and stands through the access phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (clk_en && rd_sel) begin
      if (is_tbl)
        prdata <= table_r[tbl_ix];
      else begin
        case (paddr)
          `OFS_STATUS: begin
            prdata <= 32'h0000_0000;
            prdata[`BIT_COHERENCY] <= coherency_r & ~down_s;
            prdata[`BIT_FLOW_INIT] <= flow_s;
          end
          `OFS_CONTROL:    prdata <= 32'h0000_0000;
          `OFS_IRQ_STATUS: prdata <= {{(32-`IRQ_WIDTH){1'b0}}, irq_sts_r};
          `OFS_IRQ_MASK:   prdata <= {{(32-`IRQ_WIDTH){1'b0}}, irq_mask_r};
          `OFS_ARB_CONFIG: prdata <= {31'h0, table_used_r};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // vc0_port_arb_table

// [verification/testbench.sv]
// Self-checking bench for the arbitration table block.
// Assumes the design and its constants header are compiled alongside.
`include "vc0_arb_consts.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: %h not %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic flow_init_busy = 0, is_downstream = 0, period_tick = 0, have = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r, w, ex;
  logic [3:0]  last;
  wire         pready, pslverr, grant_valid, irq;
  wire  [31:0] prdata;
  wire  [3:0]  grant_port;
  int          bad_count = 0, n_tests = 0;
  always #10 pclk = ~pclk;
  vc0_port_arb_table uut (.*);
  task automatic apb(input bit wr, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0; penable <= 0;
  endtask
  // Next phase code the arbiter should grant after p, for a table repeating word t.
  function automatic logic [3:0] next_valid(input [31:0] t, input [3:0] p);
    int i, k;
    i = 0;
    for (k = 0; k < 8; k++) if (t[4*k+:4] == p) i = k;
    for (k = 1; k < 9; k++) if (t[4*((i+k)%8)+:4] inside {0, 2, 3, 4}) return t[4*((i+k)%8)+:4];
    return p;
  endfunction
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h8B8B));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    for (int k = 0; k < 4; k++) begin
      for (int p = 0; p < 8; p++) ex[4*p+:4] = (8*k + p) % 7 + 1;
      apb(0, `OFS_TABLE0 + 4*k, 0);
      `CHK(r, ex)
    end
    apb(0, `OFS_STATUS, 0);
    `CHK(r, 32'h0)
    $display("reset values done");
    for (int k = 0; k < 4; k++) begin
      w = $urandom;
      apb(1, `OFS_TABLE0 + 4*k, w);
      apb(0, `OFS_TABLE0 + 4*k, 0);
      `CHK(r, w)
    end
    apb(1, `OFS_CONTROL, 32'h0);
    repeat (6) @(posedge pclk);
    apb(0, `OFS_STATUS, 0);
    `CHK(r[0], 1'b1)
    apb(1, `OFS_CONTROL, 32'h0001_0000);
    apb(0, `OFS_STATUS, 0);
    `CHK(r[0], 1'b1)
    repeat (6) @(posedge pclk);
    apb(0, `OFS_STATUS, 0);
    `CHK(r[0], 1'b0)
    @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(1, `OFS_IRQ_MASK, 32'h1);
    @(negedge pclk);
    `CHK(irq, 1'b1)
    apb(1, `OFS_IRQ_STATUS, 32'h1);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(0, 12'h300, 0);
    `CHK(r, 32'h0)
    $display("load and interrupt done");
    w = 32'h5F43_1F20;
    for (int k = 0; k < 4; k++) apb(1, `OFS_TABLE0 + 4*k, w);
    apb(1, `OFS_CONTROL, 32'h0001_0000);
    repeat (6) @(posedge pclk);
    repeat (300) begin
      @(posedge pclk);
      period_tick <= $urandom;
      @(negedge pclk);
      if (grant_valid === 1'b1) begin
        if (have) `CHK(grant_port, next_valid(w, last))
        last = grant_port;
        have = 1;
      end
    end
    $display("arbitration done");
    is_downstream <= 1;
    flow_init_busy <= 1;
    apb(1, `OFS_TABLE0, w);
    apb(0, `OFS_STATUS, 0);
    `CHK(r[1:0], 2'b10)
    flow_init_busy <= 0;
    repeat (4) @(posedge pclk);
    apb(0, `OFS_IRQ_STATUS, 0);
    `CHK(r[2:0], 3'b111)
    $display("downstream done");
    report_and_stop;
  end
endmodule // testbench

// [verification/vc0_arb_chk.sv]
// Port-level checker for the arbitration table block.
// Assumes one pclk domain with presetn as asynchronous active-low reset.
module vc0_arb_chk (
  // Clock and reset.
  input logic        pclk,
  input logic        presetn,
  input logic        clk_en,
  // APB.
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic        pready,
  input logic        pslverr,
  input logic [31:0] prdata,
  // Status and arbiter.
  input logic        is_downstream,
  input logic        period_tick,
  input logic [3:0]  grant_port,
  input logic        grant_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd(a);
    psel && !penable && !pwrite && clk_en && paddr == a;
  endsequence
  chk_ctrl_reads_zero: assert property (rd(12'h21C) |=> prdata == 32'h0)
    else $error("control read not zero");
  chk_status_upper: assert property (rd(12'h218) |=> prdata[31:2] == 30'h0)
    else $error("status upper bits set");
  chk_down_coh: assert property ((is_downstream && $past(is_downstream, 3)) ##0 rd(12'h218)
    |=> !prdata[0])
    else $error("downstream coherency bit set");
  chk_grant_code: assert property (grant_valid |-> grant_port inside {4'h0, 4'h2, 4'h3, 4'h4})
    else $error("grant to invalid port");
  chk_grant_tick: assert property (grant_valid && $past(clk_en) |-> $past(period_tick))
    else $error("grant without period tick");
  chk_no_wait: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  chk_bad_addr: assert property (psel && penable && paddr > 12'h238 |-> pslverr)
    else $error("unmapped access without error");
  chk_good_addr: assert property (psel && penable && paddr == 12'h220 |-> !pslverr)
    else $error("table access flagged as error");
endmodule // vc0_arb_chk

bind vc0_port_arb_table vc0_arb_chk u_chk (.*);
